// ==== hdl/standard_event_status_regs.sv ====
// standard event latch, enable mask and query reply path
`timescale 1ns/1ps
`default_nettype none
// Function
// - mask query loads decimal mask reply
// - latch query loads value, then clears
// - reply is decimal of set bits
// - opc bit set on operation complete
// - query error on read of empty queue
// - device error sets bit 3
// - execution error sets bit 4
// - command error cases set bit 5
// - local key sets bit 6
// - power cycle sets bit 7
// - summary bit from enabled set events
// - mask cleared by arst_n reset only, not by power_on_pulse
module standard_event_status_regs
  import event_status_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  input  wire logic       power_on_pulse,
  input  wire logic       opc_done,
  input  wire logic       dev_error,
  input  wire logic       exec_error,
  input  wire logic       syntax_error,
  input  wire logic       semantic_error,
  input  wire logic       get_in_message,
  input  wire logic       local_key,
  input  wire logic       clear_status,
  input  wire logic       mask_write,
  input  wire logic [7:0] mask_wdata,
  input  wire logic       mask_query,
  input  wire logic       latch_query,
  input  wire logic       talk_read,
  output logic      [7:0] talk_data,
  output logic            talk_valid,
  output logic      [7:0] latch_out,
  output logic      [7:0] mask_out,
  output logic            summary_bit
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001,
    S_D1   = 5'b00010,
    S_D2   = 5'b00100,
    S_D3   = 5'b01000,
    S_END  = 5'b10000
  } reply_type;

  logic [7:0] latch_r;
  logic [7:0] latch_nxt;
  logic [7:0] mask_r;
  logic [7:0] mask_nxt;
  logic [7:0] reply_r;
  reply_type  state_r;
  reply_type  state_nxt;
  logic [7:0] dig_h;
  logic [7:0] dig_t;
  logic [7:0] dig_o;
  logic       key_s1_r;
  logic       key_s2_r;
  logic       key_s3_r;
  logic       key_last_r;
  logic       summary_r;
  logic       valid_r;
  logic [7:0] data_r;

  // three-stage sync, change taken when stages two and three agree
  wire key_press = key_s2_r & key_s3_r & ~key_last_r;
  wire queue_empty = (state_r == S_IDLE);
  wire query_any = mask_query | latch_query;
  wire [7:0] reply_src = latch_query ? latch_r : mask_r;
  // formatter sees the new reply while idle, the held one after
  wire [7:0] fmt_in = queue_empty ? reply_src : reply_r;

  wire [7:0] events_set;
  assign events_set[BIT_OPC] = opc_done;
  assign events_set[BIT_UNUSED] = 1'b0;
  assign events_set[BIT_QYE] = talk_read & queue_empty;
  assign events_set[BIT_DDE] = dev_error;
  assign events_set[BIT_EXE] = exec_error;
  assign events_set[BIT_CME] = syntax_error | semantic_error |
                               get_in_message;
  assign events_set[BIT_URQ] = key_press;
  assign events_set[BIT_PON] = power_on_pulse;

  // clear on an accepted latch query or on clear_status, new events win
  wire clr_latch = (latch_query & queue_empty) | clear_status;
  assign latch_nxt = ((clr_latch ? LATCH_RESET : latch_r) | events_set)
                     & USED_BITS;
  assign mask_nxt = mask_write ? (mask_wdata & USED_BITS) : mask_r;

  dec_formatter u_fmt (
    .value    (fmt_in),
    .hundreds (dig_h),
    .tens     (dig_t),
    .ones     (dig_o)
  );

  // reply state walks digits then line feed
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      S_IDLE:  state_nxt = query_any ? S_D1 : S_IDLE;
      S_D1:    state_nxt = talk_read ? S_D2 : S_D1;
      S_D2:    state_nxt = talk_read ? S_D3 : S_D2;
      S_D3:    state_nxt = talk_read ? S_END : S_D3;
      S_END:   state_nxt = talk_read ? S_IDLE : S_END;
      default: state_nxt = S_IDLE;
    endcase
  end

  wire [7:0] data_sel = (state_nxt == S_D1) ? dig_h :
                        (state_nxt == S_D2) ? dig_t :
                        (state_nxt == S_D3) ? dig_o : ASCII_LF;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      key_s1_r   <= 1'b0;
      key_s2_r   <= 1'b0;
      key_s3_r   <= 1'b0;
      key_last_r <= 1'b0;
    end else if (clk_en) begin
      key_s1_r   <= local_key;
      key_s2_r   <= key_s1_r;
      key_s3_r   <= key_s2_r;
      if (key_s2_r == key_s3_r) begin
        key_last_r <= key_s3_r;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_r <= LATCH_RESET;
    end else if (clk_en) begin
      latch_r <= latch_nxt;
    end
  end

  // mask only changes on a mask write
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      mask_r <= MASK_RESET;
    end else if (clk_en) begin
      mask_r <= mask_nxt;
    end
  end

  // reply loaded from mask or latch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reply_r <= 8'h00;
      state_r <= S_IDLE;
      data_r  <= 8'h00;
      valid_r <= 1'b0;
    end else if (clk_en) begin
      state_r <= state_nxt;
      if (state_r == S_IDLE && query_any) begin
        reply_r <= reply_src;
        data_r  <= dig_h;
        valid_r <= 1'b1;
      end else if (state_r != S_IDLE && talk_read) begin
        data_r  <= data_sel;
        valid_r <= (state_nxt != S_IDLE);
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      summary_r <= 1'b0;
    end else if (clk_en) begin
      summary_r <= |(latch_nxt & mask_nxt);
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      latch_out   <= LATCH_RESET;
      mask_out    <= MASK_RESET;
    end else if (clk_en) begin
      latch_out   <= latch_nxt;
      mask_out    <= mask_nxt;
    end
  end

  assign talk_data   = data_r;
  assign talk_valid  = valid_r;
  assign summary_bit = summary_r;
endmodule : standard_event_status_regs
`default_nettype wire

// ==== inc/event_status_pkg.sv ====
// constants for the standard event status register bank
package event_status_pkg;
  localparam int unsigned REG_W       = 8;
  localparam int unsigned BIT_OPC     = 0;
  localparam int unsigned BIT_UNUSED  = 1;
  localparam int unsigned BIT_QYE     = 2;
  localparam int unsigned BIT_DDE     = 3;
  localparam int unsigned BIT_EXE     = 4;
  localparam int unsigned BIT_CME     = 5;
  localparam int unsigned BIT_URQ     = 6;
  localparam int unsigned BIT_PON     = 7;
  localparam logic [7:0]  LATCH_RESET = 8'h00;
  localparam logic [7:0]  MASK_RESET  = 8'h00;
  localparam logic [7:0]  USED_BITS   = 8'hfd;
  localparam int unsigned DEC_DIGITS  = 3;
  localparam logic [7:0]  ASCII_ZERO  = 8'h30;
  localparam logic [7:0]  ASCII_LF    = 8'h0a;
endpackage : event_status_pkg

// ==== hdl/dec_formatter.sv ====
// byte to three ascii decimal digits
`timescale 1ns/1ps
`default_nettype none
module dec_formatter
  import event_status_pkg::*;
(
  input  wire logic [7:0] value,
  output logic      [7:0] hundreds,
  output logic      [7:0] tens,
  output logic      [7:0] ones
);
  wire [7:0] h_w = value / 8'd100;
  wire [7:0] rem_w = value - 8'(h_w * 8'd100);
  wire [7:0] t_w = rem_w / 8'd10;
  wire [7:0] o_w = rem_w - 8'(t_w * 8'd10);
  assign hundreds = ASCII_ZERO + h_w;
  assign tens     = ASCII_ZERO + t_w;
  assign ones     = ASCII_ZERO + o_w;
endmodule : dec_formatter
`default_nettype wire

// ==== sim/standard_event_status_regs_asserts.sv ====
// property checker for the event status bank
`timescale 1ns/1ps
`default_nettype none
module standard_event_status_regs_asserts (
  input wire logic clk, arst_n, clk_en, power_on_pulse, opc_done, dev_error,
  input wire logic exec_error, syntax_error, semantic_error, get_in_message,
  input wire logic clear_status, mask_write, latch_query, talk_read,
  input wire logic talk_valid, summary_bit,
  input wire logic [7:0] mask_wdata, latch_out, mask_out
);
  wire logic cmd_err = syntax_error | semantic_error | get_in_message;
  wire logic calm = !(opc_done | dev_error | exec_error | cmd_err |
    power_on_pulse | talk_read);
  default clocking @(posedge clk iff clk_en); endclocking
  default disable iff (!arst_n);
  opc_set_a: assert property (opc_done |=> latch_out[0])
    else $error("opc lost");
  qye_set_a: assert property (talk_read && !talk_valid |=> latch_out[2])
    else $error("qye lost");
  dde_set_a: assert property (dev_error |=> latch_out[3])
    else $error("dde lost");
  cme_set_a: assert property (cmd_err |=> latch_out[5])
    else $error("cme lost");
  latch_clear_a: assert property (((latch_query & !talk_valid)
    | clear_status) & calm |=> (latch_out & 8'hbf) == 8'h00)
    else $error("latch kept");
  mask_keep_a: assert property (!mask_write |=> $stable(mask_out))
    else $error("mask moved");
  mask_write_a: assert property (mask_write
    |=> mask_out == ($past(mask_wdata) & 8'hfd)) else $error("mask bad");
  esb_match_a: assert property (summary_bit == |(latch_out & mask_out))
    else $error("summary bad");
endmodule : standard_event_status_regs_asserts
bind standard_event_status_regs standard_event_status_regs_asserts chk (.*);
`default_nettype wire

// ==== sim/host_model.sv ====
// host side: issues commands and reads replies
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input  wire logic [7:0] talk_data,
  input  wire logic       clk, talk_valid,
  output logic            mask_write, mask_query, latch_query, talk_read,
  output logic      [7:0] mask_wdata
);
  initial {mask_write, mask_query, latch_query, talk_read, mask_wdata} = '0;
  task automatic cmd(input int k, input logic [7:0] v);
    @(posedge clk);
    #1;
    mask_wdata = v;
    {mask_write, mask_query, latch_query} = 3'b100 >> k;
    @(posedge clk);
    #1;
    {mask_write, mask_query, latch_query} = 3'b000;
    mask_wdata = ~v;
  endtask : cmd
  task automatic fetch(output logic [11:0] v);
    v = 12'h000;
    talk_read = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (talk_valid !== 1'b1) v = 'x;
      if (i < 3) v = v * 12'd10 + 12'(talk_data) - 12'h030;
      else if (talk_data !== 8'h0a) v = 'x;
      @(posedge clk);
      #1;
    end
    talk_read = 1'b0;
  endtask : fetch
endmodule : host_model
`default_nettype wire

// ==== sim/standard_event_status_regs_tb.sv ====
// self-checking bench for the event status bank
`timescale 1ns/1ps
`default_nettype none
module standard_event_status_regs_tb;
  logic clk = 1'b0, arst_n = 1'b0, key = 1'b0, en = 1'b1;
  logic [7:0] ev = 8'h00;
  logic [11:0] v;
  wire logic [7:0] td, lo, mo, wd;
  wire logic mw, mq, lq, tr, tv, sb, pon, get, syn, exe, dde, sem, cls, opc;
  int n_errors = 0, compares = 0;
  assign {pon, get, syn, exe, dde, sem, cls, opc} = ev;
  host_model h (.clk(clk), .talk_data(td), .talk_valid(tv), .mask_write(mw),
    .mask_query(mq), .latch_query(lq), .talk_read(tr), .mask_wdata(wd));
  standard_event_status_regs uut (.clk(clk), .arst_n(arst_n), .clk_en(en),
    .power_on_pulse(pon), .opc_done(opc), .dev_error(dde), .exec_error(exe),
    .syntax_error(syn), .semantic_error(sem), .get_in_message(get),
    .local_key(key), .clear_status(cls), .mask_write(mw), .mask_wdata(wd),
    .mask_query(mq), .latch_query(lq), .talk_read(tr), .talk_data(td),
    .talk_valid(tv), .latch_out(lo), .mask_out(mo), .summary_bit(sb));
  initial forever #2.5 clk = ~clk;
  task automatic chk(input logic [11:0] g, e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("[FAIL] %0t got %0d want %0d", $time, g, e);
    end
  endtask : chk
  task automatic q(input int k, input logic [11:0] e);
    h.cmd(k, 8'h00);
    h.fetch(v);
    chk(v, e);
  endtask : q
  task automatic pulse(input logic [7:0] e);
    @(posedge clk);
    #1;
    ev = e;
    @(posedge clk);
    #1;
    ev = 8'h00;
  endtask : pulse
  task automatic finish_test;
    $display("compares %0d mismatches %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  initial begin
    #20000;
    n_errors++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge clk);
    #1;
    arst_n = 1'b1;
    q(2, 0);
    q(1, 0);
    h.cmd(0, 8'd36);
    chk(12'(mo), 36);
    q(1, 36);
    q(1, 36);
    h.cmd(0, 8'hff);
    q(1, 253);
    $display("reset and mask test done");
    for (int k = 0; k < 8; k++) if (k != 1) begin
      pulse(8'h01 << k);
      q(2, (k == 2 || k == 6) ? 32 : 1 << k);
    end
    h.cmd(0, 8'h10);
    pulse(8'h08);
    chk(12'(sb), 0);
    pulse(8'h10);
    chk(12'(sb), 1);
    pulse(8'h02);
    q(2, 0);
    q(1, 16);
    $display("event and summary test done");
    pulse(8'h30);
    chk(12'(lo), 48);
    q(2, 48);
    q(2, 0);
    h.fetch(v);
    q(2, 4);
    key = 1'b1;
    repeat (8) @(posedge clk);
    q(2, 64);
    en = 1'b0;
    pulse(8'h81);
    en = 1'b1;
    q(2, 0);
    $display("query test done");
    finish_test();
  end
endmodule : standard_event_status_regs_tb
`default_nettype wire
